// [rtl/mta_abort_counters.sv]
`timescale 1ns/1ps
`default_nettype none

`include "mta_consts.svh"

// Summary of operation
// - Count frames aborted by transmit FIFO underrun
// - Count every aborted transmit frame, any cause
// - Only device reset clears; reads never clear
// - Counts wrap to zero, never saturate
// - Underrun count bytes 0334h-0337h, MSB first
// - All-cause count bytes 0338h-033Bh, MSB first

module mta_abort_counters
	import mta_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_abort,
	input  wire logic        tx_abort_underrun
);

	// ==========================================
	// Address decode
	function automatic mta_dec_s decode(input logic [11:0] addr);
		logic [9:0] idx;
		logic [9:0] off;
		idx = addr[11:2];
		off = idx - `MTA_UNDR_IDX;
		decode.sel = MTA_SEL_NONE;
		decode.cnt_id = off[2];
		decode.lane = off[1:0];
		if (addr[1:0] == 2'h0) begin
			if (idx >= `MTA_UNDR_IDX && idx <= `MTA_ANY_IDX_END) begin
				decode.sel = MTA_SEL_COUNT;
			end else if (idx == `MTA_CTRL_IDX) begin
				decode.sel = MTA_SEL_CTRL;
			end
		end
	endfunction : decode

	// Lane 0 is the most significant byte
	function automatic logic [7:0] byte_of(input mta_count_t v, input logic [1:0] lane);
		logic [4:0] sh;
		// Built by concatenation: a product of narrow operands would drop bit 4
		sh = {(2'h3 - lane), 3'h0};
		byte_of = 8'(v >> sh);
	endfunction : byte_of

	// ==========================================
	// Counters
	logic [1:0]       inc;
	mta_count_t [1:0] live;

	assign inc[0] = tx_abort_underrun;
	assign inc[1] = tx_abort | tx_abort_underrun;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt
			mta_counter #(
				.W (`MTA_COUNT_W)
			) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.inc     (inc[gi]),
				.count   (live[gi])
			);
		end
	endgenerate

	// ==========================================
	// APB slave, zero wait states
	mta_regs_s r;
	mta_regs_s next_r;
	mta_dec_s  dec;
	logic      setup;
	logic      access;

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign dec    = decode(paddr);

	always_comb begin
		next_r = r;
		if (setup) begin
			next_r.prdata  = 32'h0000_0000;
			next_r.pslverr = 1'b0;
			unique case (dec.sel)
				MTA_SEL_COUNT: begin
					if (pwrite) begin
						next_r.pslverr = 1'b1;
					end else if (dec.lane == 2'h0) begin
						// With snap_en set, an MSB read freezes the word so the other bytes cannot tear
						next_r.prdata[7:0] = byte_of(live[dec.cnt_id], 2'h0);
						if (r.snap_en) begin
							next_r.snap[dec.cnt_id] = live[dec.cnt_id];
						end
					end else if (r.snap_en) begin
						next_r.prdata[7:0] = byte_of(r.snap[dec.cnt_id], dec.lane);
					end else begin
						next_r.prdata[7:0] = byte_of(live[dec.cnt_id], dec.lane);
					end
				end
				MTA_SEL_CTRL: begin
					next_r.prdata[`MTA_CTRL_SNAP_BIT] = r.snap_en;
				end
				MTA_SEL_NONE: begin
					next_r.pslverr = 1'b1;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end
		if (access && pwrite && dec.sel == MTA_SEL_CTRL) begin
			next_r.snap_en = pwdata[`MTA_CTRL_SNAP_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.prdata  <= 32'h0000_0000;
			r.pslverr <= 1'b0;
			r.snap_en <= `MTA_CTRL_RESET;
			r.snap    <= {2{`MTA_COUNT_RESET}};
		end else if (ce) begin
			r <= next_r;
		end
	end

	// Answer is ready in the first access cycle
	assign pready  = 1'b1;
	assign prdata  = r.prdata;
	assign pslverr = r.pslverr;

endmodule : mta_abort_counters

`default_nettype wire

// [rtl/mta_consts.svh]
`ifndef MTA_CONSTS_SVH
`define MTA_CONSTS_SVH

// ==========================================
// Register map, word indexes of byte locations
`define MTA_UNDR_IDX     10'h334
`define MTA_UNDR_IDX_END 10'h337
`define MTA_ANY_IDX      10'h338
`define MTA_ANY_IDX_END  10'h33B
`define MTA_CTRL_IDX     10'h340

// ==========================================
// Field positions and reset values
`define MTA_CTRL_SNAP_BIT 0
`define MTA_CTRL_RESET    1'h1
`define MTA_COUNT_RESET   32'h0000_0000
`define MTA_COUNT_W       32

`endif

// [rtl/mta_counter.sv]
`timescale 1ns/1ps
`default_nettype none

`include "mta_consts.svh"

module mta_counter #(
	parameter int W = `MTA_COUNT_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         inc,
	output logic [W-1:0]      count
);

	typedef struct packed {
		logic [W-1:0] value;
	} mta_cnt_s;

	mta_cnt_s r;
	mta_cnt_s next_r;

	// ==========================================
	// Free running count, wraps through zero
	always_comb begin
		next_r = r;
		if (inc) begin
			next_r.value = r.value + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Only the device reset clears the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign count = r.value;

endmodule : mta_counter

`default_nettype wire

// [rtl/mta_pkg.sv]
`include "mta_consts.svh"

package mta_pkg;

	// ==========================================
	// Types
	typedef logic [`MTA_COUNT_W-1:0] mta_count_t;

	typedef enum logic [1:0] {
		MTA_SEL_NONE,
		MTA_SEL_COUNT,
		MTA_SEL_CTRL
	} mta_sel_e;

	typedef struct packed {
		mta_sel_e   sel;
		logic       cnt_id;
		logic [1:0] lane;
	} mta_dec_s;

	typedef struct packed {
		logic [31:0]     prdata;
		logic            pslverr;
		logic            snap_en;
		mta_count_t [1:0] snap;
	} mta_regs_s;

endpackage : mta_pkg

// [tb/mta_abort_counters_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module mta_abort_counters_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Setup cycle aimed at a count byte
	sequence s_cnt(w);
		psel && !penable && ce && pwrite == w && paddr inside {[12'hCD0:12'hCEC]}
			&& paddr[1:0] == 2'h0;
	endsequence
	// Setup cycle aimed at one address
	sequence s_setup_at(a, w);
		psel && !penable && ce && pwrite == w && paddr == a;
	endsequence
	// Setup cycle with a byte offset inside the word
	sequence s_misaligned;
		psel && !penable && ce && paddr[1:0] != 2'h0;
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_byte_read: assert property (s_cnt(0) |=> !pslverr && prdata[31:8] == 24'h0)
		else $error("count byte read bad");
	a_count_ro: assert property (s_cnt(1) |=> pslverr && prdata == 32'h0)
		else $error("count write accepted");
	a_read_hold: assert property (s_cnt(0) ##1 penable |=> $stable(prdata))
		else $error("read data moved");
	a_ctrl_read: assert property (s_setup_at(12'hD00, 0) |=> !pslverr && prdata[31:1] == 31'h0)
		else $error("control read bad");
	a_bad_addr: assert property (s_misaligned |=> pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");
endmodule : mta_abort_counters_asserts
bind mta_abort_counters mta_abort_counters_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [tb/mta_abort_counters_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module mta_abort_counters_tb_top;
	import mta_pkg::*;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic        pready, pslverr, tx_abort = 0, tx_abort_underrun = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	mta_count_t  mu = 0, ma = 0;
	int          n_fail = 0, samples_checked = 0;
	always #5 pclk = ~pclk;
	mta_abort_counters dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_abort(tx_abort),
		.tx_abort_underrun(tx_abort_underrun));
	// ==========
	// Reference counts
	always @(posedge pclk) begin
		if (!presetn) {mu, ma} = '0;
		else if (ce && tx_abort_underrun) {mu, ma} = {mu + 1, ma + 1};
		else if (ce && tx_abort) ma = ma + 1;
	end
	task chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb
	task rd_cnt(input logic [11:0] base, input mta_count_t exp);
		mta_count_t v;
		for (int i = 0; i < 4; i++) begin
			apb(0, base + 12'(4 * i), 0);
			v = {v[23:0], r[7:0]};
			chk(e, 0);
		end
		chk(v, exp);
	endtask : rd_cnt
	// Pulses stop before reads so snapshot and live bytes agree
	task events(input int n);
		repeat (n) begin
			@(posedge pclk);
			ce <= $urandom % 4 != 0;
			tx_abort <= $urandom % 2;
			tx_abort_underrun <= $urandom % 3 == 0;
		end
		@(posedge pclk);
		{ce, tx_abort, tx_abort_underrun} <= 3'h4;
		// Let the last pulse reach the reference before its value is taken
		@(posedge pclk);
	endtask : events
	task print_verdict;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		#50us;
		n_fail++;
		print_verdict;
	end
	initial begin
		void'($urandom(23741));
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd_cnt(12'hCD0, 0);
		rd_cnt(12'hCE0, 0);
		events(300);
		rd_cnt(12'hCD0, mu);
		rd_cnt(12'hCE0, ma);
		apb(1, 12'hCD4, $urandom);
		chk(e, 1);
		apb(0, 12'hFFC, 0);
		chk(e, 1);
		apb(0, 12'hCD1, 0);
		chk(e, 1);
		apb(1, 12'hD00, 0);
		chk(e, 0);
		apb(0, 12'hD00, 0);
		chk(r, 0);
		events(50);
		rd_cnt(12'hCE0, ma);
		rd_cnt(12'hCE0, ma);
		rd_cnt(12'hCD0, mu);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd_cnt(12'hCD0, 0);
		rd_cnt(12'hCE0, 0);
		print_verdict;
	end
endmodule : mta_abort_counters_tb_top
`default_nettype wire
